// *** pkg/scs_map.svh ***
// Operation
// - opcode 0Bh decodes as sense request
// - held sense returns key, code, qualifier
// - no sense held returns all zero
// - sense reporting disabled after reset
// - return latest triple, never from C3
// - sense request clears the stored triple
// - later command completion replaces stored triple
// - queued auto sense setting has no effect
// - queued command error triple also returned
// - abort in hold state keeps queued triple
// - non-queued error also logged for page 10h
// - sense request invalidates logged sense data
// - sense pending needs both enables and data
// - error and sense pending may coexist
// - either enable clear: bit 1 obsolete
// - qualifier, code, key into result fields
// - B4h with feature 0011h is crypto scramble
// - crypto scramble replaces the user-data keys
// - support needs encryption covering all data
// - user data indeterminate after scramble
// - accept only supported and idle/succeeded, or failed with count bit 4 set
// - count bit 4 selects failure persistence
// - progress while running, FFFFh otherwise
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
`define SCS_A_FEAT    8'h00
`define SCS_A_SCNT    8'h04
`define SCS_A_CMD     8'h08
`define SCS_A_STAT    8'h0c
`define SCS_A_RES     8'h10
`define SCS_A_CFG     8'h14
`define SCS_A_EVT     8'h18
`define SCS_A_SAN     8'h1c
`define SCS_A_LOG     8'h20
`define SCS_OP_SENSE  8'h0b
`define SCS_OP_SAN    8'hb4
`define SCS_OP_C3     8'hc3
`define SCS_FT_CRYPTO 16'h0011
`define SCS_FT_STATUS 16'h0000
`define SCS_PROG_IDLE 16'hffff
`define SCS_SC_PERSIST 4
`define SCS_ST_ERR    0
`define SCS_ST_SENSE  1
`define SCS_ST_RDY    6
`define SCS_ST_RESET  8'h40
`define SCS_ER_ABT    2
`define SCS_CF_W119   0
`define SCS_CF_W120   1
`define SCS_CF_SANSUP 2
`define SCS_CF_ENCR   3
`define SCS_CF_NCQAS  4
`define SCS_CF_W      5
`define SCS_EV_HOLD   20
`define SCS_EV_QUEUED 21
`define SCS_EV_OP_LSB 24
`define SCS_SAN_FAIL  0
`endif

// *** pkg/scs_pkg.sv ***
package scs_pkg;
	typedef enum logic [1:0] {
		scs_sanitize_idle_state,
		scs_sanitize_running_state,
		scs_sanitize_failed_state,
		scs_sanitize_succeeded_state
	} scs_san_e;
	typedef struct packed {
		logic [3:0] key;
		logic [7:0] asc;
		logic [7:0] ascq;
	} scs_sense_s;
endpackage

// *** design/scs_top.sv ***
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"
module scs_top #(
	parameter logic [15:0] PROG_STEP = 16'h0100,
	parameter int          EPOCH_W   = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   sense_pending,
	output logic [EPOCH_W-1:0]     key_epoch,
	output scs_pkg::scs_san_e      sanitize_state
);
	import scs_pkg::*;

	// ==========================================
	// state
	logic [`SCS_CF_W-1:0] cfg_q, cfg_d;
	logic [15:0]          feat_q, feat_d;
	logic [7:0]           scnt_q, scnt_d;
	logic [7:0]           st_q, st_d;
	logic [7:0]           er_q, er_d;
	logic [23:0]          res_q, res_d;
	scs_sense_s           sense_q, sense_d;
	logic                 queued_q, queued_d;
	logic                 log_q, log_d;
	scs_san_e             san_q, san_d;
	logic                 persist_q, persist_d;
	logic [15:0]          prog_q, prog_d;
	logic [EPOCH_W-1:0]   epoch_q, epoch_d;
	logic [31:0]          prdata_q, prdata_d;
	logic                 pready_q, pready_d;
	logic                 pslverr_q, pslverr_d;
	logic                 pend_q, pend_d;

	logic       setup, wr_go, cmd_go, evt_go, fail_go, mapped;
	logic       sense_held, pend_now, cmd_abort, crypto_ok, evt_take;
	logic [7:0] op;
	logic [16:0] prog_sum;

	assign setup    = psel & ~penable;
	assign wr_go    = psel & penable & pready_q & pwrite;
	assign cmd_go   = wr_go & (paddr == `SCS_A_CMD);
	assign evt_go   = wr_go & (paddr == `SCS_A_EVT);
	assign fail_go  = wr_go & (paddr == `SCS_A_SAN) & pwdata[`SCS_SAN_FAIL];
	assign op       = pwdata[7:0];
	assign sense_held = |sense_q;
	// bit 1 only carries meaning with both identify enables set
	assign pend_now = cfg_q[`SCS_CF_W119] & cfg_q[`SCS_CF_W120] & sense_held;
	assign prog_sum = {1'b0, prog_q} + {1'b0, PROG_STEP};
	// scramble needs sanitize support and an encryption model over all data
	assign crypto_ok = cfg_q[`SCS_CF_SANSUP] & cfg_q[`SCS_CF_ENCR]
		& (san_q != scs_sanitize_running_state)
		& ~((san_q == scs_sanitize_failed_state) & ~persist_q);
	// an abort while holding a queued error leaves that triple alone
	assign evt_take = (pwdata[31:`SCS_EV_OP_LSB] != `SCS_OP_C3)
		& ~(pwdata[`SCS_EV_HOLD] & queued_q);

	// ==========================================
	// apb slave
	always_comb begin
		pready_d  = setup;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		mapped    = 1'b1;
		unique case (paddr)
			`SCS_A_FEAT: prdata_d = {16'h0000, feat_q};
			`SCS_A_SCNT: prdata_d = {24'h000000, scnt_q};
			`SCS_A_CMD:  prdata_d = 32'h00000000;
			`SCS_A_STAT: prdata_d = {16'h0000, er_q, st_q};
			`SCS_A_RES:  prdata_d = {8'h00, res_q};
			`SCS_A_CFG:  prdata_d = {27'h0000000, cfg_q};
			`SCS_A_EVT:  prdata_d = {8'h00, 3'h0, queued_q, sense_q};
			`SCS_A_SAN:  prdata_d = {5'h00, persist_q, san_q, 8'(epoch_q), prog_q};
			`SCS_A_LOG:  prdata_d = {31'h00000000, log_q};
			default:     mapped = 1'b0;
		endcase
		if (setup) begin
			pslverr_d = ~mapped;
			if (!mapped || pwrite) begin
				prdata_d = 32'h00000000;
			end
		end
	end

	// ==========================================
	// command execution
	always_comb begin
		cfg_d     = cfg_q;
		feat_d    = feat_q;
		scnt_d    = scnt_q;
		st_d      = st_q;
		er_d      = er_q;
		res_d     = res_q;
		sense_d   = sense_q;
		queued_d  = queued_q;
		log_d     = log_q;
		san_d     = san_q;
		persist_d = persist_q;
		prog_d    = prog_q;
		epoch_d   = epoch_q;
		cmd_abort = 1'b0;
		if (wr_go && paddr == `SCS_A_FEAT) begin
			feat_d = pwdata[15:0];
		end
		if (wr_go && paddr == `SCS_A_SCNT) begin
			scnt_d = pwdata[7:0];
		end
		if (wr_go && paddr == `SCS_A_CFG) begin
			cfg_d = pwdata[`SCS_CF_W-1:0];
		end
		// background key change advances until the progress counter wraps
		if (san_q == scs_sanitize_running_state) begin
			if (prog_sum[16]) begin
				san_d  = scs_sanitize_succeeded_state;
				prog_d = `SCS_PROG_IDLE;
			end else begin
				prog_d = prog_sum[15:0];
			end
			if (fail_go) begin
				san_d  = scs_sanitize_failed_state;
				prog_d = `SCS_PROG_IDLE;
			end
		end
		// completion of another command reported by firmware
		if (evt_go && evt_take) begin
			sense_d  = pwdata[19:0];
			queued_d = pwdata[`SCS_EV_QUEUED];
			log_d    = ~pwdata[`SCS_EV_QUEUED] & (|pwdata[19:0]);
		end
		if (cmd_go) begin
			st_d = 8'h00;
			st_d[`SCS_ST_RDY] = 1'b1;
			er_d = 8'h00;
			unique case (op)
				`SCS_OP_SENSE: begin
					// auto sense setting is deliberately not consulted
					res_d    = {4'h0, sense_q.key, sense_q.asc, sense_q.ascq};
					sense_d  = '0;
					queued_d = 1'b0;
					log_d    = 1'b0;
				end
				`SCS_OP_SAN: begin
					if (feat_q == `SCS_FT_CRYPTO && crypto_ok) begin
						san_d     = scs_sanitize_running_state;
						persist_d = scnt_q[`SCS_SC_PERSIST];
						prog_d    = 16'h0000;
						epoch_d   = epoch_q + 1'b1;
						res_d     = 24'h000000;
					end else if (feat_q == `SCS_FT_STATUS) begin
						res_d = {8'h00, prog_q};
						if (san_q == scs_sanitize_failed_state && persist_q) begin
							san_d = scs_sanitize_idle_state;
						end
					end else begin
						cmd_abort = 1'b1;
					end
				end
				default: cmd_abort = 1'b1;
			endcase
			if (cmd_abort) begin
				er_d[`SCS_ER_ABT] = 1'b1;
				st_d[`SCS_ST_ERR] = 1'b1;
			end
		end
		st_d[`SCS_ST_SENSE] = cfg_d[`SCS_CF_W119] & cfg_d[`SCS_CF_W120] & (|sense_d);
		pend_d = st_d[`SCS_ST_SENSE];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q     <= '0;
			feat_q    <= 16'h0000;
			scnt_q    <= 8'h00;
			st_q      <= `SCS_ST_RESET;
			er_q      <= 8'h00;
			res_q     <= 24'h000000;
			sense_q   <= '0;
			queued_q  <= 1'b0;
			log_q     <= 1'b0;
			san_q     <= scs_sanitize_idle_state;
			persist_q <= 1'b0;
			prog_q    <= `SCS_PROG_IDLE;
			epoch_q   <= '0;
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			pend_q    <= 1'b0;
		end else begin
			cfg_q     <= cfg_d;
			feat_q    <= feat_d;
			scnt_q    <= scnt_d;
			st_q      <= st_d;
			er_q      <= er_d;
			res_q     <= res_d;
			sense_q   <= sense_d;
			queued_q  <= queued_d;
			log_q     <= log_d;
			san_q     <= san_d;
			persist_q <= persist_d;
			prog_q    <= prog_d;
			epoch_q   <= epoch_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			pend_q    <= pend_d;
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign sense_pending  = pend_q;
	assign key_epoch      = epoch_q;
	assign sanitize_state = san_q;

	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic sense_cmd, crypto_cmd, stat_cmd;
	assign sense_cmd  = cmd_go && op == `SCS_OP_SENSE;
	assign crypto_cmd = cmd_go && op == `SCS_OP_SAN && feat_q == `SCS_FT_CRYPTO;
	assign stat_cmd   = cmd_go && op == `SCS_OP_SAN && feat_q == `SCS_FT_STATUS;
	logic        other_cmd, persist_sel, evt_queued;
	logic [19:0] evt_triple;
	assign other_cmd   = cmd_go && op != `SCS_OP_SENSE && op != `SCS_OP_SAN;
	assign evt_triple  = pwdata[19:0];
	assign evt_queued  = pwdata[`SCS_EV_QUEUED];
	assign persist_sel = scnt_q[`SCS_SC_PERSIST];

	sequence s_scramble_taken;
		crypto_cmd && crypto_ok && !fail_go;
	endsequence
	sequence s_running_fresh;
		san_q == scs_sanitize_running_state && prog_q == 16'h0000;
	endsequence
	sequence s_running_step;
		san_q == scs_sanitize_running_state && !prog_sum[16] && !fail_go;
	endsequence
	sequence s_running_wrap;
		san_q == scs_sanitize_running_state && prog_sum[16] && !fail_go;
	endsequence
	sequence s_running_fail;
		san_q == scs_sanitize_running_state && fail_go;
	endsequence

	property p_sense_consume;
		sense_cmd && !evt_go |=> sense_q == '0 && !log_q
			&& res_q == {4'h0, $past(sense_q)};
	endproperty
	a_sense_consume: assert property (p_sense_consume) else $error("sense not consumed");

	property p_pend;
		pend_q == pend_now;
	endproperty
	a_pend: assert property (p_pend) else $error("sense pending mismatch");

	property p_c3_skip;
		evt_go && pwdata[31:`SCS_EV_OP_LSB] == `SCS_OP_C3 && !cmd_go |=> $stable(sense_q);
	endproperty
	a_c3_skip: assert property (p_c3_skip) else $error("c3 result captured");

	property p_hold_keep;
		evt_go && pwdata[`SCS_EV_HOLD] && queued_q && !cmd_go |=> $stable(sense_q);
	endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("queued triple overwritten");

	property p_scramble_start;
		s_scramble_taken |=> s_running_fresh ##0 epoch_q == $past(epoch_q) + 1'b1;
	endproperty
	a_scramble_start: assert property (p_scramble_start) else $error("scramble not started");

	property p_scramble_refuse;
		crypto_cmd && !crypto_ok |=> er_q[`SCS_ER_ABT] && st_q[`SCS_ST_ERR] && $stable(epoch_q);
	endproperty
	a_scramble_refuse: assert property (p_scramble_refuse) else $error("refusal wrong");

	property p_prog_idle;
		san_q != scs_sanitize_running_state |-> prog_q == `SCS_PROG_IDLE;
	endproperty
	a_prog_idle: assert property (p_prog_idle) else $error("progress not idle value");

	property p_persist_exit;
		stat_cmd && san_q == scs_sanitize_failed_state && persist_q
			|=> san_q == scs_sanitize_idle_state;
	endproperty
	a_persist_exit: assert property (p_persist_exit) else $error("failed state kept");

	property p_stuck_fail;
		crypto_cmd && san_q == scs_sanitize_failed_state && !persist_q |=> er_q[`SCS_ER_ABT]
			&& san_q == scs_sanitize_failed_state && $stable(epoch_q);
	endproperty
	a_stuck_fail: assert property (p_stuck_fail) else $error("scramble accepted");

	property p_apb_ready;
		setup |=> pready_q ##1 !pready_q;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("pready timing");

	property p_sense_empty;
		sense_cmd && !sense_held |=> res_q == 24'h000000;
	endproperty
	a_sense_empty: assert property (p_sense_empty) else $error("empty sense not zero");

	property p_sense_status;
		sense_cmd |=> st_q[`SCS_ST_RDY] && !st_q[`SCS_ST_ERR] && er_q == 8'h00;
	endproperty
	a_sense_status: assert property (p_sense_status) else $error("sense status wrong");

	property p_evt_capture;
		evt_go && evt_take |=> sense_q == $past(evt_triple);
	endproperty
	a_evt_capture: assert property (p_evt_capture) else $error("triple not replaced");

	property p_queued_mark;
		evt_go && evt_take |=> queued_q == $past(evt_queued);
	endproperty
	a_queued_mark: assert property (p_queued_mark) else $error("queued mark wrong");

	property p_log_capture;
		evt_go && evt_take && !evt_queued && evt_triple != 20'h00000 |=> log_q;
	endproperty
	a_log_capture: assert property (p_log_capture) else $error("log flag not set");

	property p_err_and_pend;
		other_cmd && pend_now |=> st_q[`SCS_ST_ERR] && st_q[`SCS_ST_SENSE];
	endproperty
	a_err_and_pend: assert property (p_err_and_pend) else $error("error hides pending");

	property p_obsolete;
		!(cfg_q[`SCS_CF_W119] && cfg_q[`SCS_CF_W120]) |-> !st_q[`SCS_ST_SENSE] && !pend_q;
	endproperty
	a_obsolete: assert property (p_obsolete) else $error("pending without enables");

	property p_prog_step;
		s_running_step |=> prog_q == $past(prog_q) + PROG_STEP;
	endproperty
	a_prog_step: assert property (p_prog_step) else $error("progress step wrong");

	property p_scramble_done;
		s_running_wrap |=> san_q == scs_sanitize_succeeded_state && prog_q == `SCS_PROG_IDLE;
	endproperty
	a_scramble_done: assert property (p_scramble_done) else $error("scramble not done");

	property p_run_fail;
		s_running_fail |=> san_q == scs_sanitize_failed_state && prog_q == `SCS_PROG_IDLE;
	endproperty
	a_run_fail: assert property (p_run_fail) else $error("failure not taken");

	property p_other_abort;
		other_cmd |=> er_q[`SCS_ER_ABT] && st_q[`SCS_ST_ERR];
	endproperty
	a_other_abort: assert property (p_other_abort) else $error("unknown not aborted");

	property p_stuck_status;
		stat_cmd && san_q == scs_sanitize_failed_state && !persist_q |=> san_q == scs_sanitize_failed_state;
	endproperty
	a_stuck_status: assert property (p_stuck_status) else $error("failed state left");

	property p_epoch_hold;
		!(crypto_cmd && crypto_ok) |=> $stable(epoch_q);
	endproperty
	a_epoch_hold: assert property (p_epoch_hold) else $error("keys changed unasked");

	property p_persist_take;
		s_scramble_taken |=> persist_q == $past(persist_sel);
	endproperty
	a_persist_take: assert property (p_persist_take) else $error("persistence not kept");
endmodule
`default_nettype wire

// *** test/scs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host controller: issues register cycles
module scs_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rdata;
	logic        rerr;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data lines show no stale value
		pwdata <= ~d;
		paddr <= ~a;
		@(posedge pclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
endmodule
`default_nettype wire

// *** test/sense_and_crypto_sanitize_cmds_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR %0t: got %h expected %h", $time, a, b); end end
module sense_and_crypto_sanitize_cmds_test;
	import scs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sense_pending;
	logic [7:0]  paddr, key_epoch;
	logic [31:0] pwdata, prdata;
	scs_san_e    sanitize_state;
	int          num_errors, checks;
	scs_top #(.PROG_STEP(16'h1000), .EPOCH_W(8)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_pending(sense_pending),
		.key_epoch(key_epoch), .sanitize_state(sanitize_state));
	scs_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		host.rd(a);
		`CHK(host.rdata, e)
	endtask
	task end_of_test;
		if (num_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#200us;
		num_errors++;
		end_of_test();
	end
	// ==========================================
	// main sequence
	initial begin
		num_errors = 0;
		checks = 0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`SCS_A_CFG, 32'h0);
		rchk(`SCS_A_STAT, 32'h40);
		rchk(`SCS_A_SAN, 32'h0000_ffff);
		host.rd(8'h40);
		`CHK(host.rerr, 1'b1)
		host.wr(`SCS_A_CFG, 32'h3);
		host.wr(`SCS_A_EVT, 32'h2f05_2401);
		`CHK(sense_pending, 1'b1)
		host.wr(`SCS_A_EVT, 32'hc307_0000);
		rchk(`SCS_A_EVT, 32'h0005_2401);
		host.wr(`SCS_A_CFG, 32'h1);
		`CHK(sense_pending, 1'b0)
		host.wr(`SCS_A_CFG, 32'h13);
		rchk(`SCS_A_STAT, 32'h42);
		host.wr(`SCS_A_EVT, 32'h2003_1100);
		host.wr(`SCS_A_CMD, 32'h77);
		rchk(`SCS_A_STAT, 32'h443);
		host.wr(`SCS_A_CMD, 32'h0b);
		rchk(`SCS_A_RES, 32'h0003_1100);
		`CHK(sense_pending, 1'b0)
		host.wr(`SCS_A_CMD, 32'h0b);
		rchk(`SCS_A_RES, 32'h0);
		host.wr(`SCS_A_EVT, 32'h602b_4e00);
		host.wr(`SCS_A_EVT, 32'h2f15_0000);
		rchk(`SCS_A_EVT, 32'h001b_4e00);
		host.wr(`SCS_A_CMD, 32'h0b);
		rchk(`SCS_A_RES, 32'h000b_4e00);
		host.wr(`SCS_A_EVT, 32'h2004_1100);
		rchk(`SCS_A_LOG, 32'h1);
		host.wr(`SCS_A_CMD, 32'h0b);
		rchk(`SCS_A_LOG, 32'h0);
		// sanitize refused while unsupported
		host.wr(`SCS_A_CFG, 32'h8);
		host.wr(`SCS_A_FEAT, 32'h0011);
		host.wr(`SCS_A_SCNT, 32'h10);
		host.wr(`SCS_A_CMD, 32'hb4);
		rchk(`SCS_A_STAT, 32'h441);
		`CHK(key_epoch, 8'd0)
		host.wr(`SCS_A_CFG, 32'hc);
		host.wr(`SCS_A_CMD, 32'hb4);
		`CHK(sanitize_state, scs_sanitize_running_state)
		`CHK(key_epoch, 8'd1)
		rchk(`SCS_A_SAN, 32'h0501_2000);
		for (int i = 0; i < 40 && sanitize_state !== scs_sanitize_succeeded_state; i++)
			@(posedge pclk);
		rchk(`SCS_A_SAN, 32'h0701_ffff);
		host.wr(`SCS_A_CMD, 32'hb4);
		host.wr(`SCS_A_SAN, 32'h1);
		`CHK(sanitize_state, scs_sanitize_failed_state)
		host.wr(`SCS_A_CMD, 32'hb4);
		`CHK(key_epoch, 8'd3)
		host.wr(`SCS_A_CMD, 32'hb4);
		`CHK(key_epoch, 8'd3)
		host.wr(`SCS_A_SAN, 32'h1);
		host.wr(`SCS_A_FEAT, 32'h0);
		host.wr(`SCS_A_CMD, 32'hb4);
		rchk(`SCS_A_RES, 32'h0000_ffff);
		`CHK(sanitize_state, scs_sanitize_idle_state)
		host.wr(`SCS_A_FEAT, 32'h0011);
		host.wr(`SCS_A_SCNT, 32'h0);
		host.wr(`SCS_A_CMD, 32'hb4);
		host.wr(`SCS_A_SAN, 32'h1);
		host.wr(`SCS_A_CMD, 32'hb4);
		`CHK(key_epoch, 8'd4)
		rchk(`SCS_A_STAT, 32'h441);
		host.wr(`SCS_A_FEAT, 32'h0);
		host.wr(`SCS_A_CMD, 32'hb4);
		`CHK(sanitize_state, scs_sanitize_failed_state)
		rchk(`SCS_A_RES, 32'h0000_ffff);
		end_of_test();
	end
endmodule
`default_nettype wire
